// File: common/dofs_pkg.sv
// Purpose: shared constants and state type of the digital output selector
// Assumes: 10 MHz pclk, apb register access
// Notes:   selection codes are 6 bits, 64 entries
`default_nettype none
package dofs_pkg;

    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_KHZ       = 10000;
    localparam int TICK_TIME_MS  = 1;
    localparam int TICK_CYCLES   = TICK_TIME_MS * CLK_KHZ;
    localparam int INDEX_HOLD_MS = 10;
    localparam int INDEX_CYCLES  = INDEX_HOLD_MS * CLK_KHZ;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_SEL_RELAY_A = 8'h00;
    localparam logic [7:0] ADDR_SEL_RELAY_B = 8'h04;
    localparam logic [7:0] ADDR_SEL_TRANS   = 8'h08;
    localparam logic [7:0] ADDR_SEL_FAST    = 8'h0c;
    localparam logic [7:0] ADDR_CTRL        = 8'h10;
    localparam logic [7:0] ADDR_VIRT        = 8'h14;
    localparam logic [7:0] ADDR_ALARM_OV    = 8'h18;
    localparam logic [7:0] ADDR_ALARM_UN    = 8'h1c;
    localparam logic [7:0] ADDR_STATUS      = 8'h20;

    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int TERM_RELAY_A = 0;
    localparam int TERM_RELAY_B = 1;
    localparam int TERM_TRANS   = 2;
    localparam int TERM_FAST    = 3;
    localparam int CTRL_FAST_DIGITAL = 0;
    localparam int ST_OV_ALARM   = 8;
    localparam int ST_UN_ALARM   = 9;
    localparam int ST_INDEX_ACT  = 10;
    localparam logic [5:0] RST_SEL_RELAY_A = 6'h01;
    localparam logic [5:0] RST_SEL_RELAY_B = 6'h05;
    localparam logic [5:0] RST_SEL_TRANS   = 6'h00;
    localparam logic [5:0] RST_SEL_FAST    = 6'h00;

    // ---------------------------------------------------------------
    // selection codes
    // ---------------------------------------------------------------
    localparam int C_RUN = 1, C_FWD = 2, C_REV = 3, C_JOG = 4, C_FAULT = 5;
    localparam int C_FLD_A = 6, C_FLD_B = 7, C_FREACH = 8, C_ZERO = 9;
    localparam int C_UPPER = 10, C_LOWER = 11, C_READY = 12, C_PREEX = 13;
    localparam int C_OVLD = 14, C_UNLD = 15, C_STAGE = 16, C_CYCLE = 17;
    localparam int C_VIRT0 = 23, C_VIRT1 = 24, C_VIRT2 = 25, C_DCBUS = 26;
    localparam int C_INDEX = 27, C_SUPER = 28, C_STO = 29, C_POS = 30;
    localparam int C_SPZERO = 31, C_SPDIV = 32, C_SPLIM = 33, C_VIRT3 = 34;
    localparam int C_MODESW = 36;

    typedef struct packed {
        logic [3:0][5:0] sel;
        logic            fast_digital;
        logic [15:0]     virt;
        logic [15:0]     ov_time;
        logic [15:0]     un_time;
        logic [15:0]     tick_cnt;
        logic [15:0]     ov_cnt;
        logic [15:0]     un_cnt;
        logic            ov_alarm;
        logic            un_alarm;
        logic            idx_s1;
        logic            idx_s2;
        logic            idx_d;
        logic [19:0]     idx_cnt;
        logic [3:0]      outs;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } dofs_state_t;

endpackage

`default_nettype wire

// File: logic/dofs_top.sv
// Purpose: routes drive status conditions to four output terminals
// Assumes: status inputs come from logic on pclk, index pulse from a pin
// Notes:   registers over apb, one wait state on every transfer
`timescale 1ns/1ps
`default_nettype none

module dofs_top #(
    parameter int TICK_CYCLES  = dofs_pkg::TICK_CYCLES,
    parameter int INDEX_CYCLES = dofs_pkg::INDEX_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        running,
    input  wire logic        forward,
    input  wire logic        reverse,
    input  wire logic        jogging,
    input  wire logic        freq_present,
    input  wire logic        drive_fault,
    input  wire logic        freq_level_detect_a,
    input  wire logic        freq_level_detect_b,
    input  wire logic        freq_reached,
    input  wire logic        out_freq_zero,
    input  wire logic        ref_freq_zero,
    input  wire logic        at_upper_limit,
    input  wire logic        at_lower_limit,
    input  wire logic        main_power_ok,
    input  wire logic        ctrl_power_ok,
    input  wire logic        protection_active,
    input  wire logic        ready_to_run,
    input  wire logic        pre_exciting,
    input  wire logic        overload_over,
    input  wire logic        underload_over,
    input  wire logic        seq_stage_done,
    input  wire logic        seq_cycle_done,
    input  wire logic        dc_bus_ok,
    input  wire logic        index_pulse_in,
    input  wire logic        pulse_superpose,
    input  wire logic        safe_torque_off,
    input  wire logic        position_done,
    input  wire logic        spindle_zero_done,
    input  wire logic        spindle_div_done,
    input  wire logic        speed_limited,
    input  wire logic        mode_switch_done,
    input  wire logic        fast_pulse_src,
    output var  logic        relay_out_a,
    output var  logic        relay_out_b,
    output var  logic        trans_out,
    output var  logic        fast_pulse_out
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    dofs_pkg::dofs_state_t s_r;
    dofs_pkg::dofs_state_t s_nxt;

    logic [63:0] cond;
    logic [3:0]  term_act;
    logic        tick;
    logic        idx_active;

    assign tick = (s_r.tick_cnt == 16'(TICK_CYCLES - 1));
    assign idx_active = (s_r.idx_cnt != 20'h00000);

    // ---------------------------------------------------------------
    // condition vector, one bit per selection code
    // ---------------------------------------------------------------
    // unlisted bits stay zero so reserved codes read as no function
    always_comb begin
        cond = 64'h0;
        cond[dofs_pkg::C_RUN]    = running & freq_present;
        cond[dofs_pkg::C_FWD]    = running & forward & freq_present;
        cond[dofs_pkg::C_REV]    = running & reverse & freq_present;
        cond[dofs_pkg::C_JOG]    = jogging & freq_present;
        cond[dofs_pkg::C_FAULT]  = drive_fault;
        cond[dofs_pkg::C_FLD_A]  = freq_level_detect_a;
        cond[dofs_pkg::C_FLD_B]  = freq_level_detect_b;
        cond[dofs_pkg::C_FREACH] = freq_reached;
        cond[dofs_pkg::C_ZERO]   = running & out_freq_zero & ref_freq_zero;
        cond[dofs_pkg::C_UPPER]  = running & at_upper_limit;
        cond[dofs_pkg::C_LOWER]  = running & at_lower_limit;
        cond[dofs_pkg::C_READY]  = main_power_ok & ctrl_power_ok
                                 & ~protection_active & ready_to_run;
        cond[dofs_pkg::C_PREEX]  = pre_exciting;
        cond[dofs_pkg::C_OVLD]   = s_r.ov_alarm;
        cond[dofs_pkg::C_UNLD]   = s_r.un_alarm;
        cond[dofs_pkg::C_STAGE]  = seq_stage_done;
        cond[dofs_pkg::C_CYCLE]  = seq_cycle_done;
        cond[dofs_pkg::C_DCBUS]  = dc_bus_ok;
        cond[dofs_pkg::C_INDEX]  = idx_active;
        cond[dofs_pkg::C_SUPER]  = pulse_superpose;
        cond[dofs_pkg::C_STO]    = safe_torque_off;
        cond[dofs_pkg::C_POS]    = position_done;
        cond[dofs_pkg::C_SPZERO] = spindle_zero_done;
        cond[dofs_pkg::C_SPDIV]  = spindle_div_done;
        cond[dofs_pkg::C_SPLIM]  = speed_limited;
        cond[dofs_pkg::C_MODESW] = mode_switch_done;
    end

    // ---------------------------------------------------------------
    // per-terminal selection
    // ---------------------------------------------------------------
    // each terminal picks its own bit, so shared codes just fan out;
    // virtual bits are per terminal, nibble per communication source
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_term
            logic [5:0] code;
            logic       virt_hit;
            assign code = s_r.sel[gi];
            always_comb begin
                case (code)
                    6'(dofs_pkg::C_VIRT0): virt_hit = s_r.virt[gi];
                    6'(dofs_pkg::C_VIRT1): virt_hit = s_r.virt[4 + gi];
                    6'(dofs_pkg::C_VIRT2): virt_hit = s_r.virt[8 + gi];
                    6'(dofs_pkg::C_VIRT3): virt_hit = s_r.virt[12 + gi];
                    default: virt_hit = 1'b0;
                endcase
            end
            assign term_act[gi] = cond[code] | virt_hit;
        end
    endgenerate

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // 1 ms tick for the pre-alarm timers
        if (tick) begin
            s_nxt.tick_cnt = 16'h0000;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
        end

        // pre-alarm: count whole ms while over threshold, drop at once
        if (!overload_over) begin
            s_nxt.ov_cnt   = 16'h0000;
            s_nxt.ov_alarm = 1'b0;
        end else if (s_r.ov_cnt >= s_r.ov_time) begin
            s_nxt.ov_alarm = 1'b1;
        end else if (tick) begin
            s_nxt.ov_cnt = s_r.ov_cnt + 16'h0001;
        end
        if (!underload_over) begin
            s_nxt.un_cnt   = 16'h0000;
            s_nxt.un_alarm = 1'b0;
        end else if (s_r.un_cnt >= s_r.un_time) begin
            s_nxt.un_alarm = 1'b1;
        end else if (tick) begin
            s_nxt.un_cnt = s_r.un_cnt + 16'h0001;
        end

        // index pulse comes from a pin: sync first, edge on second stage
        s_nxt.idx_s1 = index_pulse_in;
        s_nxt.idx_s2 = s_r.idx_s1;
        s_nxt.idx_d  = s_r.idx_s2;
        // a new pulse restarts the hold window rather than extending it
        if (s_r.idx_s2 && !s_r.idx_d) begin
            s_nxt.idx_cnt = 20'(INDEX_CYCLES);
        end else if (idx_active) begin
            s_nxt.idx_cnt = s_r.idx_cnt - 20'h00001;
        end

        // terminals
        s_nxt.outs[dofs_pkg::TERM_RELAY_A] = term_act[dofs_pkg::TERM_RELAY_A];
        s_nxt.outs[dofs_pkg::TERM_RELAY_B] = term_act[dofs_pkg::TERM_RELAY_B];
        s_nxt.outs[dofs_pkg::TERM_TRANS]   = term_act[dofs_pkg::TERM_TRANS];
        if (s_r.fast_digital) begin
            s_nxt.outs[dofs_pkg::TERM_FAST] = term_act[dofs_pkg::TERM_FAST];
        end else begin
            s_nxt.outs[dofs_pkg::TERM_FAST] = fast_pulse_src;
        end

        // apb: one wait state, write and read data at the pready edge
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0;
            case (paddr)
                dofs_pkg::ADDR_SEL_RELAY_A: s_nxt.prdata[5:0] = s_r.sel[0];
                dofs_pkg::ADDR_SEL_RELAY_B: s_nxt.prdata[5:0] = s_r.sel[1];
                dofs_pkg::ADDR_SEL_TRANS:   s_nxt.prdata[5:0] = s_r.sel[2];
                dofs_pkg::ADDR_SEL_FAST:    s_nxt.prdata[5:0] = s_r.sel[3];
                dofs_pkg::ADDR_CTRL:
                    s_nxt.prdata[dofs_pkg::CTRL_FAST_DIGITAL] = s_r.fast_digital;
                dofs_pkg::ADDR_VIRT:        s_nxt.prdata[15:0] = s_r.virt;
                dofs_pkg::ADDR_ALARM_OV:    s_nxt.prdata[15:0] = s_r.ov_time;
                dofs_pkg::ADDR_ALARM_UN:    s_nxt.prdata[15:0] = s_r.un_time;
                dofs_pkg::ADDR_STATUS: begin
                    s_nxt.prdata[3:0] = s_r.outs;
                    s_nxt.prdata[dofs_pkg::ST_OV_ALARM]  = s_r.ov_alarm;
                    s_nxt.prdata[dofs_pkg::ST_UN_ALARM]  = s_r.un_alarm;
                    s_nxt.prdata[dofs_pkg::ST_INDEX_ACT] = idx_active;
                    s_nxt.pslverr = pwrite;
                end
                default: s_nxt.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && s_r.pready && pwrite && !s_r.pslverr) begin
            case (paddr)
                dofs_pkg::ADDR_SEL_RELAY_A: s_nxt.sel[0] = pwdata[5:0];
                dofs_pkg::ADDR_SEL_RELAY_B: s_nxt.sel[1] = pwdata[5:0];
                dofs_pkg::ADDR_SEL_TRANS:   s_nxt.sel[2] = pwdata[5:0];
                dofs_pkg::ADDR_SEL_FAST:    s_nxt.sel[3] = pwdata[5:0];
                dofs_pkg::ADDR_CTRL:
                    s_nxt.fast_digital = pwdata[dofs_pkg::CTRL_FAST_DIGITAL];
                dofs_pkg::ADDR_VIRT:        s_nxt.virt = pwdata[15:0];
                dofs_pkg::ADDR_ALARM_OV:    s_nxt.ov_time = pwdata[15:0];
                dofs_pkg::ADDR_ALARM_UN:    s_nxt.un_time = pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r        <= '0;
            s_r.sel[0] <= dofs_pkg::RST_SEL_RELAY_A;
            s_r.sel[1] <= dofs_pkg::RST_SEL_RELAY_B;
            s_r.sel[2] <= dofs_pkg::RST_SEL_TRANS;
            s_r.sel[3] <= dofs_pkg::RST_SEL_FAST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata         = s_r.prdata;
    assign pready         = s_r.pready;
    assign pslverr        = s_r.pslverr;
    assign relay_out_a    = s_r.outs[dofs_pkg::TERM_RELAY_A];
    assign relay_out_b    = s_r.outs[dofs_pkg::TERM_RELAY_B];
    assign trans_out      = s_r.outs[dofs_pkg::TERM_TRANS];
    assign fast_pulse_out = s_r.outs[dofs_pkg::TERM_FAST];

endmodule

`default_nettype wire

// File: tb/dofs_top_assertions.sv
// Purpose: port level checks of the digital output selector
// Assumes: bound to dofs_top; code shadows follow apb writes that end without pslverr
// Notes:   terminal checks look one edge back, since the output register follows the code register and inputs one edge later
`timescale 1ns/1ps
`default_nettype none
module dofs_top_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        running,
    input wire logic        freq_present,
    input wire logic        drive_fault,
    input wire logic        fast_pulse_src,
    input wire logic        relay_out_a,
    input wire logic        relay_out_b,
    input wire logic        trans_out,
    input wire logic        fast_pulse_out
);
    // ---------------------------------------------------------------
    // register shadows
    // ---------------------------------------------------------------
    logic [5:0] sel_a_r, sel_b_r, sel_t_r;
    logic       fast_dig_r;
    logic       wok;
    logic       run_c;
    assign wok   = psel & penable & pready & pwrite & ~pslverr;
    assign run_c = running & freq_present;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_a_r    <= dofs_pkg::RST_SEL_RELAY_A;
            sel_b_r    <= dofs_pkg::RST_SEL_RELAY_B;
            sel_t_r    <= dofs_pkg::RST_SEL_TRANS;
            fast_dig_r <= 1'b0;
        end else if (wok) begin
            if (paddr == dofs_pkg::ADDR_SEL_RELAY_A) sel_a_r <= pwdata[5:0];
            if (paddr == dofs_pkg::ADDR_SEL_RELAY_B) sel_b_r <= pwdata[5:0];
            if (paddr == dofs_pkg::ADDR_SEL_TRANS) sel_t_r <= pwdata[5:0];
            if (paddr == dofs_pkg::ADDR_CTRL) fast_dig_r <= pwdata[0];
        end
    end
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("apb answer not after exactly one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_bad_addr: assert property (psel && penable && pready && (paddr[1:0] != 2'h0 || paddr > 8'h20) |-> pslverr)
        else $error("unmapped address without pslverr");
    a_status_ro: assert property (psel && penable && pready && pwrite && paddr == dofs_pkg::ADDR_STATUS |-> pslverr)
        else $error("status write accepted");
    a_run_relay: assert property ($past(presetn) && $past(sel_a_r) == 6'h01 |-> relay_out_a == $past(run_c))
        else $error("relay a does not follow running with frequency");
    a_fault_relay: assert property ($past(presetn) && $past(sel_b_r) == 6'h05 |-> relay_out_b == $past(drive_fault))
        else $error("relay b does not follow drive fault");
    a_code_zero: assert property ($past(presetn) && $past(sel_t_r) == 6'h00 |-> !trans_out)
        else $error("transistor output active with code zero");
    a_fast_pass: assert property ($past(presetn) && !$past(fast_dig_r) |-> fast_pulse_out == $past(fast_pulse_src))
        else $error("fast terminal does not pass the pulse source");
    c_write: cover property (wok);
    c_refused: cover property (pready && pslverr);
    c_shared: cover property (relay_out_b && trans_out);
endmodule
`default_nettype wire

// File: tb/dofs_load.sv
// Purpose: external wiring on the four terminals, counts switch-on events
// Assumes: terminals are active high levels on pclk
// Notes:   counters wrap at 255, enough for short runs
`timescale 1ns/1ps
`default_nettype none
module dofs_load (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  term,
    output var  logic [31:0] rise_r
);
    logic [3:0] lvl_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_r  <= 4'h0;
            rise_r <= 32'h0;
        end else begin
            lvl_r <= term;
            for (int t = 0; t < 4; t++) begin
                if (term[t] && !lvl_r[t]) rise_r[8*t +: 8] <= rise_r[8*t +: 8] + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_dofs_top.sv
// Purpose: self-checking bench of the digital output selector
// Assumes: short counts, tick 10 cycles and index hold 50 cycles
// Notes:   condition inputs travel as one vector, bit order follows the port list
`timescale 1ns/1ps
`default_nettype none
module tb_dofs_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [29:0] cnd = 30'h0;
    logic        idx = 1'b0, fsrc = 1'b0;
    logic [31:0] prdata, rise, q;
    logic        pready, pslverr, ra, rb, to, fo, e;
    logic [7:0]  n0;
    int          error_cnt = 0;
    int          check_count = 0;
    int          codes [25] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 26, 28, 29, 30, 31, 32, 33, 36};
    logic [29:0] masks [25] = '{30'h11, 30'h13, 30'h15, 30'h18, 30'h20, 30'h40, 30'h80, 30'h100, 30'h601, 30'h801,
        30'h1001, 30'h16000, 30'h20000, 30'h40000, 30'h80000, 30'h100000, 30'h200000, 30'h400000, 30'h800000,
        30'h1000000, 30'h2000000, 30'h4000000, 30'h8000000, 30'h10000000, 30'h20000000};
    int          vcode [4] = '{23, 24, 25, 34};
    always #50 pclk = ~pclk;
    dofs_top #(.TICK_CYCLES(10), .INDEX_CYCLES(50)) u_dofs_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .running(cnd[0]),
        .forward(cnd[1]), .reverse(cnd[2]), .jogging(cnd[3]), .freq_present(cnd[4]), .drive_fault(cnd[5]),
        .freq_level_detect_a(cnd[6]), .freq_level_detect_b(cnd[7]), .freq_reached(cnd[8]),
        .out_freq_zero(cnd[9]), .ref_freq_zero(cnd[10]), .at_upper_limit(cnd[11]), .at_lower_limit(cnd[12]),
        .main_power_ok(cnd[13]), .ctrl_power_ok(cnd[14]), .protection_active(cnd[15]), .ready_to_run(cnd[16]),
        .pre_exciting(cnd[17]), .overload_over(cnd[18]), .underload_over(cnd[19]), .seq_stage_done(cnd[20]),
        .seq_cycle_done(cnd[21]), .dc_bus_ok(cnd[22]), .index_pulse_in(idx), .pulse_superpose(cnd[23]),
        .safe_torque_off(cnd[24]), .position_done(cnd[25]), .spindle_zero_done(cnd[26]),
        .spindle_div_done(cnd[27]), .speed_limited(cnd[28]), .mode_switch_done(cnd[29]), .fast_pulse_src(fsrc),
        .relay_out_a(ra), .relay_out_b(rb), .trans_out(to), .fast_pulse_out(fo));
    dofs_load u_dofs_load (.pclk(pclk), .presetn(presetn), .term({fo, to, rb, ra}), .rise_r(rise));
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic results();
        $display("mismatches %0d comparisons %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            results();
        end
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic errc(input logic w, input logic [7:0] a);
        apb(w, a, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask
    task automatic setc(input logic [29:0] m);
        @(posedge pclk);
        cnd <= m;
        repeat (3) @(posedge pclk);
    endtask
    task automatic tchk(input logic b);
        repeat (2) @(posedge pclk);
        chk({31'h0, to}, {31'h0, b});
    endtask
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rdc(8'(4 * i), i == 0 ? 32'h1 : (i == 1 ? 32'h5 : 32'h0));
        errc(1'b0, 8'h24);
        errc(1'b0, 8'h02);
        errc(1'b1, dofs_pkg::ADDR_STATUS);
        wr(dofs_pkg::ADDR_ALARM_OV, 32'h0);
        wr(dofs_pkg::ADDR_ALARM_UN, 32'h0);
        for (int i = 0; i < 25; i++) begin
            wr(dofs_pkg::ADDR_SEL_TRANS, 32'(codes[i]));
            setc(masks[i]);
            tchk(1'b1);
            setc(masks[i] & (masks[i] - 30'h1));
            tchk(1'b0);
        end
        wr(dofs_pkg::ADDR_SEL_TRANS, 32'hc);
        setc(30'h1e000);
        tchk(1'b0);
        setc(30'h3fffffff);
        for (int c = 0; c < 64; c++) begin
            if (c == 0 || (c >= 18 && c <= 22) || c == 35 || c >= 37) begin
                wr(dofs_pkg::ADDR_SEL_TRANS, 32'(c));
                tchk(1'b0);
            end
        end
        setc(30'h0);
        for (int k = 0; k < 4; k++) begin
            wr(dofs_pkg::ADDR_VIRT, ~(32'h1 << (4 * k + 2)) & 32'hffff);
            wr(dofs_pkg::ADDR_SEL_TRANS, 32'(vcode[k]));
            tchk(1'b0);
            wr(dofs_pkg::ADDR_VIRT, 32'h1 << (4 * k + 2));
            tchk(1'b1);
        end
        rdc(dofs_pkg::ADDR_VIRT, 32'h4000);
        wr(dofs_pkg::ADDR_ALARM_OV, 32'h2);
        rdc(dofs_pkg::ADDR_ALARM_OV, 32'h2);
        wr(dofs_pkg::ADDR_SEL_TRANS, 32'he);
        setc(30'h40000);
        chk({31'h0, to}, 32'h0);
        repeat (30) @(posedge pclk);
        chk({31'h0, to}, 32'h1);
        setc(30'h0);
        // index hold: pulse one cycle, stays on for the hold window only
        wr(dofs_pkg::ADDR_SEL_TRANS, 32'h1b);
        n0 = rise[23:16];
        @(posedge pclk);
        idx <= 1'b1;
        @(posedge pclk);
        idx <= 1'b0;
        repeat (6) @(posedge pclk);
        chk({31'h0, to}, 32'h1);
        repeat (40) @(posedge pclk);
        chk({31'h0, to}, 32'h1);
        repeat (15) @(posedge pclk);
        chk({31'h0, to}, 32'h0);
        chk({24'h0, rise[23:16] - n0}, 32'h1);
        @(posedge pclk);
        fsrc <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({31'h0, fo}, 32'h1);
        fsrc <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, fo}, 32'h0);
        wr(dofs_pkg::ADDR_CTRL, 32'h1);
        wr(dofs_pkg::ADDR_SEL_FAST, 32'h5);
        wr(dofs_pkg::ADDR_SEL_RELAY_A, 32'h5);
        wr(dofs_pkg::ADDR_SEL_TRANS, 32'h5);
        setc(30'h20);
        chk({28'h0, fo, to, rb, ra}, 32'hf);
        rdc(dofs_pkg::ADDR_STATUS, 32'hf);
        // mid-run reset with the fault still on: codes and mode fall back to reset values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({28'h0, fo, to, rb, ra}, 32'h0);
        presetn <= 1'b1;
        rdc(dofs_pkg::ADDR_CTRL, 32'h0);
        chk({28'h0, fo, to, rb, ra}, 32'h2);
        setc(30'h0);
        chk({28'h0, fo, to, rb, ra}, 32'h0);
        results();
    end
endmodule
bind dofs_top dofs_top_assertions u_dofs_top_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .running(running), .freq_present(freq_present),
    .drive_fault(drive_fault), .fast_pulse_src(fast_pulse_src), .relay_out_a(relay_out_a),
    .relay_out_b(relay_out_b), .trans_out(trans_out), .fast_pulse_out(fast_pulse_out));
`default_nettype wire
